// ==== src/vectored_interrupt_controller.sv ====
// vectored interrupt controller: flags, masks, groups, vectors, standby release
// assumes an axi4-lite master and a core that acknowledges offered vectors
//
// Function
// - watchdog nmi outranks all, ignores disable
// - nmi releases halt
// - watchdog is sole nmi source, mode-routed
// - per-source group bit; high nests over low
// - same group resolved by fixed order 0..17
// - maskable request releases stop and halt
// - five external, thirteen internal maskable sources
// - software break vectors to 003EH always
// - fixed vector per maskable source
// - flag sets on event or software one
// - flag clears on acknowledge, write, reset
// - flags reset zero; byte and word access
// - first flag register layout
// - second flag register layout, bit 2 zero
// - watchdog controls act only as interval timer
// - mask one blocks; masks reset ones
// - nmi accept clears enable and service priority
// - rise and fall enables pick pin edge
// - flag one means pending
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module vectored_interrupt_controller
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // axi4-lite write address and data
    input wire logic [vic_pkg::AW-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    // axi4-lite write response
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // axi4-lite read
    input wire logic [vic_pkg::AW-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // request sources
    input wire logic WDT_OVF_I,
    input wire logic WDT_NMI_MODE_I,
    input wire logic [3:0] PIN_I,
    input wire logic [11:0] EVT_I,
    input wire logic KEY_EDGE_I,
    input wire logic BRK_I,
    // core side
    input wire logic ACK_I,
    input wire logic RETI_I,
    input wire logic PSW_LOAD_I,
    input wire logic PSW_IE_I,
    input wire logic PSW_ISP_I,
    output logic IRQ_O,
    output logic [1:0] KIND_O,
    output logic [15:0] VECTOR_O,
    output logic IE_O,
    output logic ISP_O,
    output logic HALT_REL_O,
    output logic STOP_REL_O
);
    import vic_pkg::*;

    // whole controller state
    typedef struct packed {
        logic [17:0] flag;
        logic [17:0] mask;
        logic [17:0] prio;
        logic [3:0] rise;
        logic [3:0] fall;
        logic ie;
        logic in_service_priority;
        logic nmi_pend;
        logic nmi_busy;
        logic brk_pend;
        logic aw_full;
        logic [AW-1:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awrdy;
        logic wrdy;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
        kind_e kind;
        logic [4:0] sel;
        logic [15:0] vec;
        logic halt_rel;
        logic stop_rel;
    } st_s;

    st_s q;
    st_s d;
    logic [3:0] pin_evt; // edge requests from the pin block
    logic [17:0] evt; // hardware set events this cycle
    logic [17:0] live; // flags that may wake or be served
    logic wr_fire; // register write performed this cycle
    logic [4:0] pick_idx; // winner among maskable requests
    logic pick_ok;

    // edge selection for the four pins
    // valid edge per pin
    pin_edge_detect u_pins
    (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .pin_i(PIN_I),
        .rise_en_i(q.rise),
        .fall_en_i(q.fall),
        .edge_o(pin_evt)
    );

    // vector for a maskable source; 0018H is skipped
    function automatic logic [15:0] vec_of(input logic [4:0] i);
        logic [15:0] off;
        off = {10'h000, i, 1'b0};
        if (i < SRC_GAP)
        begin
            return VEC_WDT + off;
        end
        return VEC_WDT + VEC_GAP_STEP + off;
    endfunction

    // byte-lane merge; only lane 0 carries a byte register
    function automatic logic [7:0] merge8(input logic [7:0] old,
        input logic [31:0] w, input logic [3:0] s, input int lane);
        return s[lane] ? w[lane*8 +: 8] : old;
    endfunction

    // read decode: {hit, data}
    function automatic logic [32:0] rd_reg(input logic [15:0] idx);
        logic [23:0] fw;
        logic [23:0] mw;
        logic [23:0] pw;
        fw = pack_src(q.flag, 1'b0);
        mw = pack_src(q.mask, 1'b1);
        pw = pack_src(q.prio, 1'b1);
        unique case (idx)
            IDX_IF_LOW: return {1'b1, 24'h00_0000, fw[7:0]};
            IDX_IF_HIGH: return {1'b1, 24'h00_0000, fw[15:8]};
            IDX_IF_EXTRA: return {1'b1, 24'h00_0000, fw[23:16]};
            IDX_IF_WORD: return {1'b1, 16'h0000, fw[15:0]};
            IDX_MK_LOW: return {1'b1, 24'h00_0000, mw[7:0]};
            IDX_MK_HIGH: return {1'b1, 24'h00_0000, mw[15:8]};
            IDX_MK_EXTRA: return {1'b1, 24'h00_0000, mw[23:16]};
            IDX_MK_WORD: return {1'b1, 16'h0000, mw[15:0]};
            IDX_PR_LOW: return {1'b1, 24'h00_0000, pw[7:0]};
            IDX_PR_HIGH: return {1'b1, 24'h00_0000, pw[15:8]};
            IDX_PR_EXTRA: return {1'b1, 24'h00_0000, pw[23:16]};
            IDX_PR_WORD: return {1'b1, 16'h0000, pw[15:0]};
            IDX_EDGE_RISE: return {1'b1, 28'h000_0000, q.rise};
            IDX_EDGE_FALL: return {1'b1, 28'h000_0000, q.fall};
            IDX_CTRL: return {1'b1, 27'h000_0000, WDT_NMI_MODE_I,
                q.nmi_pend, q.nmi_busy, q.in_service_priority, q.ie};
            IDX_STAT: return {1'b1, q.irq, 8'h00, q.kind, q.sel, q.vec};
            default: return {1'b0, 32'h0000_0000};
        endcase
    endfunction

    // hardware events; the watchdog goes one way only
    // watchdog routing
    always_comb
    begin
        evt = '0;
        evt[SRC_WDT] = WDT_OVF_I & ~WDT_NMI_MODE_I;
        evt[SRC_PIN0 +: 4] = pin_evt;
        evt[SRC_EVT0 +: 12] = EVT_I;
        evt[SRC_KEY] = KEY_EDGE_I;
    end

    // watchdog bits drop out in nmi mode
    // interval-timer only
    assign live = q.flag & ~q.mask & {17'h1_FFFF, ~WDT_NMI_MODE_I};
    assign wr_fire = q.aw_full & q.w_full & ~q.bvalid;

    // group first, then lowest index; isp low blocks all maskables
    // high group first
    always_comb
    begin
        logic [17:0] ok;
        logic [17:0] hi;
        logic [17:0] pick;
        ok = live & {18{q.ie & q.in_service_priority & ~q.nmi_busy}};
        hi = ok & ~q.prio;
        pick = (|hi) ? hi : ok;
        pick_idx = 5'h00;
        pick_ok = |pick;
        for (int k = NSRC - 1; k >= 0; k--)
        begin
            if (pick[k])
            begin
                pick_idx = 5'(k);
            end
        end
    end

    // next state: bus, registers, acknowledge, offer
    always_comb
    begin
        logic [23:0] fw;
        logic [23:0] mw;
        logic [23:0] pw;
        logic [15:0] widx;
        logic hit;
        logic taken;
        logic [32:0] rd;
        fw = pack_src(q.flag, 1'b0);
        mw = pack_src(q.mask, 1'b1);
        pw = pack_src(q.prio, 1'b1);
        widx = q.awaddr[AW-1:2];
        hit = 1'b1;
        taken = q.irq & ACK_I;
        rd = rd_reg(ARADDR_I[AW-1:2]);
        d = q;
        // capture address and data in either order
        if (AWVALID_I && q.awrdy)
        begin
            d.aw_full = 1'b1;
            d.awaddr = AWADDR_I;
        end
        if (WVALID_I && q.wrdy)
        begin
            d.w_full = 1'b1;
            d.wdata = WDATA_I;
            d.wstrb = WSTRB_I;
        end
        // software writes; ones set, zeros clear
        // byte and word forms
        if (wr_fire)
        begin
            unique case (widx)
                IDX_IF_LOW: fw[7:0] = merge8(fw[7:0], q.wdata, q.wstrb, 0);
                IDX_IF_HIGH: fw[15:8] = merge8(fw[15:8], q.wdata, q.wstrb, 0);
                IDX_IF_EXTRA: fw[23:16] = merge8(fw[23:16], q.wdata, q.wstrb, 0);
                IDX_IF_WORD:
                begin
                    fw[7:0] = merge8(fw[7:0], q.wdata, q.wstrb, 0);
                    fw[15:8] = merge8(fw[15:8], q.wdata, q.wstrb, 1);
                end
                IDX_MK_LOW: mw[7:0] = merge8(mw[7:0], q.wdata, q.wstrb, 0);
                IDX_MK_HIGH: mw[15:8] = merge8(mw[15:8], q.wdata, q.wstrb, 0);
                IDX_MK_EXTRA: mw[23:16] = merge8(mw[23:16], q.wdata, q.wstrb, 0);
                IDX_MK_WORD:
                begin
                    mw[7:0] = merge8(mw[7:0], q.wdata, q.wstrb, 0);
                    mw[15:8] = merge8(mw[15:8], q.wdata, q.wstrb, 1);
                end
                IDX_PR_LOW: pw[7:0] = merge8(pw[7:0], q.wdata, q.wstrb, 0);
                IDX_PR_HIGH: pw[15:8] = merge8(pw[15:8], q.wdata, q.wstrb, 0);
                IDX_PR_EXTRA: pw[23:16] = merge8(pw[23:16], q.wdata, q.wstrb, 0);
                IDX_PR_WORD:
                begin
                    pw[7:0] = merge8(pw[7:0], q.wdata, q.wstrb, 0);
                    pw[15:8] = merge8(pw[15:8], q.wdata, q.wstrb, 1);
                end
                IDX_EDGE_RISE: d.rise = q.wstrb[0] ? q.wdata[3:0] : q.rise;
                IDX_EDGE_FALL: d.fall = q.wstrb[0] ? q.wdata[3:0] : q.fall;
                IDX_CTRL:
                begin
                    d.ie = q.wstrb[0] ? q.wdata[CTRL_IE] : q.ie;
                    d.in_service_priority = q.wstrb[0] ? q.wdata[CTRL_ISP] : q.in_service_priority;
                end
                IDX_STAT: hit = 1'b1;
                default: hit = 1'b0;
            endcase
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (q.bvalid && BREADY_I)
        begin
            d.bvalid = 1'b0;
        end
        // fixed bits dropped by unpacking
        // first layout
        d.flag = unpack_src(fw);
        d.mask = unpack_src(mw);
        d.prio = unpack_src(pw);
        // watchdog flag held at zero while it routes to nmi
        // flag inert
        d.flag[SRC_WDT] = d.flag[SRC_WDT] & ~WDT_NMI_MODE_I;
        // core loads its status word (ei, di, return, pop)
        if (PSW_LOAD_I)
        begin
            d.ie = PSW_IE_I;
            d.in_service_priority = PSW_ISP_I;
        end
        // return ends nmi service
        if (RETI_I)
        begin
            d.nmi_busy = 1'b0;
        end
        // acknowledge of the offered request
        if (taken)
        begin
            unique case (q.kind)
                KIND_NMI:
                begin
                    d.nmi_pend = 1'b0;
                    d.nmi_busy = 1'b1;
                    d.ie = 1'b0;
                    d.in_service_priority = 1'b0;
                end
                KIND_BRK:
                begin
                    d.brk_pend = 1'b0;
                    d.ie = 1'b0;
                end
                KIND_MASK:
                begin
                    d.flag[q.sel] = 1'b0;
                    d.ie = 1'b0;
                    d.in_service_priority = q.prio[q.sel];
                end
                KIND_NONE: d.ie = q.ie;
            endcase
        end
        // new break beats the ack
        if (BRK_I)
        begin
            d.brk_pend = 1'b1;
        end
        // events win over any clear in the same cycle
        // set on event
        d.flag = d.flag | evt;
        // repeats during service fold into one pending nmi
        // nmi captured always
        if (WDT_OVF_I && WDT_NMI_MODE_I)
        begin
            d.nmi_pend = 1'b1;
        end
        // read path: one answer per address, unmapped gets slverr
        if (ARVALID_I && q.arrdy)
        begin
            d.rvalid = 1'b1;
            d.rdata = rd[31:0];
            d.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end
        else if (q.rvalid && RREADY_I)
        begin
            d.rvalid = 1'b0;
        end
        // free while no answer waits; write channels also need their slot empty
        d.arrdy = ~d.rvalid;
        d.awrdy = ~d.aw_full & ~d.bvalid;
        d.wrdy = ~d.w_full & ~d.bvalid;
        // offer: nmi, then break, then maskable
        // nmi outranks all
        d.kind = KIND_NONE;
        d.vec = q.vec;
        d.sel = q.sel;
        if (q.nmi_pend && !q.nmi_busy)
        begin
            d.kind = KIND_NMI;
            d.vec = VEC_NMI;
        end
        else if (q.brk_pend)
        begin
            d.kind = KIND_BRK;
            d.vec = VEC_BRK;
        end
        else if (pick_ok)
        begin
            d.kind = KIND_MASK;
            d.sel = pick_idx;
            d.vec = vec_of(pick_idx);
        end
        d.irq = (d.kind != KIND_NONE) & ~taken;
        // standby wake-ups
        // nmi ends halt
        d.stop_rel = |live;
        d.halt_rel = q.nmi_pend | (|live);
    end

    // state register
    // flags reset to zero
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            q <= '0;
            q.flag <= FLAG_RST;
            q.mask <= MASK_RST;
            q.prio <= PRIO_RST;
            q.rise <= EDGE_RST;
            q.fall <= EDGE_RST;
            q.ie <= CTRL_RST[CTRL_IE];
            q.in_service_priority <= CTRL_RST[CTRL_ISP];
            q.kind <= KIND_NONE;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign AWREADY_O = q.awrdy;
    assign WREADY_O = q.wrdy;
    assign BVALID_O = q.bvalid;
    assign BRESP_O = q.bresp;
    assign ARREADY_O = q.arrdy;
    assign RVALID_O = q.rvalid;
    assign RDATA_O = q.rdata;
    assign RRESP_O = q.rresp;
    assign IRQ_O = q.irq;
    assign KIND_O = q.kind;
    assign VECTOR_O = q.vec;
    assign IE_O = q.ie;
    assign ISP_O = q.in_service_priority;
    assign HALT_REL_O = q.halt_rel;
    assign STOP_REL_O = q.stop_rel;

    // checks
    property p_nmi_first;
        @(posedge CLK_I) disable iff (RST_I)
        (q.nmi_pend && !q.nmi_busy && !(ACK_I && q.irq))
            |=> (IRQ_O && KIND_O == KIND_NMI);
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi not offered first");

    property p_nmi_halt;
        @(posedge CLK_I) disable iff (RST_I)
        q.nmi_pend |=> HALT_REL_O;
    endproperty
    a_nmi_halt: assert property (p_nmi_halt) else $error("nmi did not release halt");

    property p_nmi_vec;
        @(posedge CLK_I) disable iff (RST_I)
        (IRQ_O && KIND_O == KIND_NMI) |-> VECTOR_O == VEC_NMI;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");

    property p_group_gate;
        @(posedge CLK_I) disable iff (RST_I)
        (IRQ_O && KIND_O == KIND_MASK) |-> $past(q.in_service_priority) && $past(q.ie);
    endproperty
    a_group_gate: assert property (p_group_gate) else $error("maskable offered while blocked");

    property p_stop_rel;
        @(posedge CLK_I) disable iff (RST_I)
        (|live) |=> (STOP_REL_O && HALT_REL_O);
    endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("maskable did not release standby");

    sequence s_brk_quiet;
        BRK_I && !q.nmi_pend && !WDT_OVF_I ##1 !ACK_I && !q.nmi_pend;
    endsequence
    property p_brk;
        @(posedge CLK_I) disable iff (RST_I)
        s_brk_quiet |=> (IRQ_O && KIND_O == KIND_BRK && VECTOR_O == VEC_BRK);
    endproperty
    a_brk: assert property (p_brk) else $error("break not offered at its vector");

    property p_mask_vec;
        @(posedge CLK_I) disable iff (RST_I)
        (IRQ_O && KIND_O == KIND_MASK)
            |-> (!VECTOR_O[0] && VECTOR_O >= VEC_WDT && VECTOR_O <= VEC_LAST);
    endproperty
    a_mask_vec: assert property (p_mask_vec) else $error("maskable vector out of table");

    property p_flag_set;
        @(posedge CLK_I) disable iff (RST_I)
        (|evt) |=> ((q.flag & $past(evt)) == $past(evt));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost its flag");

    property p_nmi_ack;
        @(posedge CLK_I) disable iff (RST_I)
        (ACK_I && IRQ_O && KIND_O == KIND_NMI && !PSW_LOAD_I)
            |=> (!IE_O && !ISP_O && q.nmi_busy) ##1 !IRQ_O;
    endproperty
    a_nmi_ack: assert property (p_nmi_ack) else $error("nmi accept left enables set");

    c_nmi: cover property (@(posedge CLK_I) disable iff (RST_I)
        IRQ_O && KIND_O == KIND_NMI && ACK_I);
    c_nest: cover property (@(posedge CLK_I) disable iff (RST_I)
        IRQ_O && KIND_O == KIND_MASK && ISP_O && ACK_I ##[1:50] IRQ_O && ACK_I);
    c_wr_rd: cover property (@(posedge CLK_I) disable iff (RST_I)
        BVALID_O && BREADY_I ##[1:20] RVALID_O && RREADY_I);
endmodule
`default_nettype wire

// ==== inc/vic_pkg.sv ====
// constants, types and helpers for the vectored interrupt controller
// assumes an axi4-lite master with 32-bit data and word-aligned registers
package vic_pkg;

    // source count and default-order positions
    localparam int NSRC = 18;
    localparam int SRC_WDT = 0;
    localparam int SRC_PIN0 = 1;
    localparam int SRC_EVT0 = 5;
    localparam int SRC_KEY = 17;
    localparam logic [4:0] SRC_GAP = 5'h0A;

    // register indices; byte address is four times the index
    localparam int AW = 18;
    localparam logic [15:0] IDX_IF_LOW = 16'hFFE0;
    localparam logic [15:0] IDX_IF_HIGH = 16'hFFE1;
    localparam logic [15:0] IDX_IF_EXTRA = 16'hFFE2;
    localparam logic [15:0] IDX_MK_LOW = 16'hFFE4;
    localparam logic [15:0] IDX_MK_HIGH = 16'hFFE5;
    localparam logic [15:0] IDX_MK_EXTRA = 16'hFFE6;
    localparam logic [15:0] IDX_PR_LOW = 16'hFFE8;
    localparam logic [15:0] IDX_PR_HIGH = 16'hFFE9;
    localparam logic [15:0] IDX_PR_EXTRA = 16'hFFEA;
    localparam logic [15:0] IDX_EDGE_RISE = 16'hFF48;
    localparam logic [15:0] IDX_EDGE_FALL = 16'hFF49;
    localparam logic [15:0] IDX_IF_WORD = 16'hFFF0;
    localparam logic [15:0] IDX_MK_WORD = 16'hFFF1;
    localparam logic [15:0] IDX_PR_WORD = 16'hFFF2;
    localparam logic [15:0] IDX_CTRL = 16'hFFF4;
    localparam logic [15:0] IDX_STAT = 16'hFFF5;

    // reset values
    localparam logic [17:0] FLAG_RST = 18'h0_0000;
    localparam logic [17:0] MASK_RST = 18'h3_FFFF;
    localparam logic [17:0] PRIO_RST = 18'h3_FFFF;
    localparam logic [3:0] EDGE_RST = 4'h0;
    localparam logic [7:0] CTRL_RST = 8'h02;

    // control register fields
    localparam int CTRL_IE = 0;
    localparam int CTRL_ISP = 1;
    localparam int CTRL_NMI_BUSY = 2;
    localparam int CTRL_NMI_PEND = 3;
    localparam int CTRL_NMI_MODE = 4;

    // vectors
    localparam logic [15:0] VEC_NMI = 16'h0004;
    localparam logic [15:0] VEC_WDT = 16'h0004;
    localparam logic [15:0] VEC_GAP_STEP = 16'h0002;
    localparam logic [15:0] VEC_BRK = 16'h003E;
    localparam logic [15:0] VEC_LAST = 16'h0028;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // kind of the request offered to the core
    typedef enum logic [1:0] {
        KIND_NONE = 2'b00,
        KIND_NMI = 2'b01,
        KIND_BRK = 2'b10,
        KIND_MASK = 2'b11
    } kind_e;

    // spread 18 sources over three byte registers; fill goes to fixed bits
    function automatic logic [23:0] pack_src(input logic [17:0] v, input logic fill);
        return {{5{fill}}, v[17:15], v[14:10], fill, v[9:8], v[7:0]};
    endfunction

    // gather the 18 sources back from three byte registers
    function automatic logic [17:0] unpack_src(input logic [23:0] w);
        return {w[18:16], w[15:11], w[9:8], w[7:0]};
    endfunction

endpackage

// ==== src/pin_edge_detect.sv ====
// edge detector for the four external request pins
// assumes pins already synchronous to the clock
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins and edge selection
    input wire logic [3:0] pin_i,
    input wire logic [3:0] rise_en_i,
    input wire logic [3:0] fall_en_i,
    // one-cycle request per valid edge
    output logic [3:0] edge_o
);
    // previous pin level and registered event
    typedef struct packed {
        logic [3:0] prev;
        logic [3:0] evt;
    } pin_s;

    pin_s q;
    pin_s d;
    logic [3:0] hit;

    // per pin: neither enable blocks, one picks its edge, both take both
    for (genvar g = 0; g < 4; g++)
    begin : g_pin
        assign hit[g] = (rise_en_i[g] & pin_i[g] & ~q.prev[g])
            | (fall_en_i[g] & ~pin_i[g] & q.prev[g]);
    end

    // next state
    always_comb
    begin
        d = q;
        d.prev = pin_i;
        d.evt = hit;
    end

    // a pin high at reset release looks like a rising edge once if its rise enable is already set
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign edge_o = q.evt;
endmodule
`default_nettype wire

// ==== verification/core_model.sv ====
// stand-in for the processor core: acknowledges each offer
// assumes the offer stands until it is acknowledged
`timescale 1ns/1ns
`default_nettype none
module core_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // offer in, answer out
    input wire logic irq_i,
    input wire logic [3:0] dly_i,
    output logic ack_o
);
    logic [3:0] cnt_q; // cycles the offer has stood
    // one-cycle ack after dly_i cycles; never twice for one offer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 4'h0;
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= irq_i && !ack_o && cnt_q == dly_i;
            cnt_q <= (irq_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// bench for the vectored interrupt controller
// assumes core_model acknowledges every offer
`timescale 1ns/1ns
`default_nettype none
module tb;
    import vic_pkg::*;
    logic CLK_I = 0, RST_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0;
    logic ARVALID_I = 0, RREADY_I = 0, WDT_OVF_I = 0, WDT_NMI_MODE_I = 0;
    logic KEY_EDGE_I = 0, BRK_I = 0, RETI_I = 0, PSW_LOAD_I = 0, ACK_I;
    logic [17:0] AWADDR_I = '0, ARADDR_I = '0;
    logic [31:0] WDATA_I = '0, RDATA_O;
    logic [3:0] WSTRB_I = '0, PIN_I = '0, dly = 4'h2;
    logic [11:0] EVT_I = '0;
    logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
    logic IE_O, ISP_O, HALT_REL_O, STOP_REL_O;
    logic [1:0] BRESP_O, RRESP_O, KIND_O;
    logic [15:0] VECTOR_O;
    int n_mismatch = 0, checked = 0;
    // vectors of event sources 5..16
    logic [15:0] vt [12] = '{16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h001A,
        16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026};
    vectored_interrupt_controller uut (.CLK_I, .RST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O,
        .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I,
        .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .WDT_OVF_I,
        .WDT_NMI_MODE_I, .PIN_I, .EVT_I, .KEY_EDGE_I, .BRK_I, .ACK_I, .RETI_I, .PSW_LOAD_I,
        .PSW_IE_I(1'b1), .PSW_ISP_I(1'b1), .IRQ_O, .KIND_O, .VECTOR_O, .IE_O, .ISP_O,
        .HALT_REL_O, .STOP_REL_O);
    core_model core (.clk_i(CLK_I), .rst_i(RST_I), .irq_i(IRQ_O), .dly_i(dly), .ack_o(ACK_I));
    initial forever #2 CLK_I = ~CLK_I;
    task print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t saw %h want %h", $time, s, e);
        end
    endtask
    // a wait that ran out ends the run
    task to();
        n_mismatch++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
    endtask
    // axi write; both channels offered together, bready held until bvalid
    task wr(input logic [15:0] i, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        @(posedge CLK_I);
        AWADDR_I <= {i, 2'b00};
        WDATA_I <= d;
        WSTRB_I <= s;
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        BREADY_I <= 1'b1;
        for (n = 0; n < 40 && !BVALID_O; n++)
        begin
            @(posedge CLK_I);
            if (AWREADY_O) AWVALID_I <= 1'b0;
            if (WREADY_O) WVALID_I <= 1'b0;
        end
        BREADY_I <= 1'b0;
        if (n == 40) to();
        chk({30'h0, BRESP_O}, {30'h0, r});
    endtask
    // axi read; rready held until rvalid
    task rd(input logic [15:0] i, input logic [31:0] e);
        int n;
        @(posedge CLK_I);
        ARADDR_I <= {i, 2'b00};
        ARVALID_I <= 1'b1;
        RREADY_I <= 1'b1;
        for (n = 0; n < 40 && !RVALID_O; n++)
        begin
            @(posedge CLK_I);
            if (ARREADY_O) ARVALID_I <= 1'b0;
        end
        RREADY_I <= 1'b0;
        if (n == 40) to();
        chk(RDATA_O, e);
        chk({30'h0, RRESP_O}, 32'h0);
    endtask
    // wait for an offer, compare it, then wait until it is taken
    task exp(input logic [1:0] k, input logic [15:0] v);
        int n;
        for (n = 0; n < 20 && IRQ_O !== 1'b1; n++) @(posedge CLK_I);
        if (n == 20) to();
        chk({30'h0, KIND_O}, {30'h0, k});
        chk({16'h0, VECTOR_O}, {16'h0, v});
        chk({31'h0, HALT_REL_O}, {31'h0, k != KIND_BRK});
        if (k == KIND_MASK) chk({31'h0, STOP_REL_O}, 32'h1);
        for (n = 0; n < 20 && IRQ_O !== 1'b0; n++) @(posedge CLK_I);
        if (n == 20) to();
    endtask
    // core restores enable and service priority
    task en();
        @(posedge CLK_I);
        PSW_LOAD_I <= 1'b1;
        @(posedge CLK_I);
        PSW_LOAD_I <= 1'b0;
    endtask
    // no offer may stand after six cycles; only the last cycle is sampled
    task quiet();
        repeat (6) @(posedge CLK_I);
        chk({31'h0, IRQ_O}, 32'h0);
    endtask
    initial
    begin
        repeat (4) @(posedge CLK_I);
        RST_I <= 1'b0;
        chk({IRQ_O, IE_O, ISP_O}, 32'h1);
        wr(16'hFF00, 32'h0, 4'h1, RESP_SLVERR);
        wr(IDX_MK_WORD, 32'h0, 4'h3, RESP_OKAY);
        wr(IDX_MK_EXTRA, 32'h0, 4'h1, RESP_OKAY);
        en();
        // each event source alone, one row each
        for (int i = 0; i < 12; i++)
        begin
            @(posedge CLK_I);
            EVT_I <= 12'h001 << i;
            @(posedge CLK_I);
            EVT_I <= 12'h000;
            exp(KIND_MASK, vt[i]);
            chk({31'h0, IE_O}, 32'h0);
            en();
        end
        // same group, then high group first
        for (int g = 0; g < 2; g++)
        begin
            @(posedge CLK_I);
            EVT_I <= 12'h801;
            @(posedge CLK_I);
            EVT_I <= 12'h000;
            exp(KIND_MASK, g ? 16'h0026 : 16'h000E);
            en();
            exp(KIND_MASK, g ? 16'h000E : 16'h0026);
            en();
            wr(IDX_PR_EXTRA, 32'hFD, 4'h1, RESP_OKAY);
        end
        wr(IDX_MK_EXTRA, 32'h4, 4'h1, RESP_OKAY);
        @(posedge CLK_I);
        KEY_EDGE_I <= 1'b1;
        @(posedge CLK_I);
        KEY_EDGE_I <= 1'b0;
        quiet();
        wr(IDX_MK_EXTRA, 32'h0, 4'h1, RESP_OKAY);
        exp(KIND_MASK, VEC_LAST);
        en();
        wr(IDX_IF_LOW, 32'h2, 4'h1, RESP_OKAY);
        exp(KIND_MASK, 16'h0006);
        en();
        wr(IDX_IF_HIGH, 32'h1, 4'h1, RESP_OKAY);
        exp(KIND_MASK, 16'h0014);
        en();
        wr(IDX_EDGE_RISE, 32'h1, 4'h1, RESP_OKAY);
        wr(IDX_EDGE_FALL, 32'h2, 4'h1, RESP_OKAY);
        PIN_I <= 4'h3;
        exp(KIND_MASK, 16'h0006);
        en();
        PIN_I <= 4'h0;
        exp(KIND_MASK, 16'h0008);
        BRK_I <= 1'b1;
        @(posedge CLK_I);
        BRK_I <= 1'b0;
        exp(KIND_BRK, VEC_BRK);
        en();
        dly <= 4'h0;
        WDT_NMI_MODE_I <= 1'b1;
        WDT_OVF_I <= 1'b1;
        EVT_I <= 12'h001;
        @(posedge CLK_I);
        WDT_OVF_I <= 1'b0;
        EVT_I <= 12'h000;
        exp(KIND_NMI, VEC_NMI);
        chk({IE_O, ISP_O}, 32'h0);
        quiet();
        RETI_I <= 1'b1;
        @(posedge CLK_I);
        RETI_I <= 1'b0;
        en();
        exp(KIND_MASK, 16'h000E);
        en();
        WDT_NMI_MODE_I <= 1'b0;
        WDT_OVF_I <= 1'b1;
        @(posedge CLK_I);
        WDT_OVF_I <= 1'b0;
        exp(KIND_MASK, VEC_WDT);
        rd(IDX_IF_HIGH, 32'h0);
        rd(IDX_PR_LOW, 32'hFF);
        print_verdict();
    end
endmodule
`default_nettype wire
